// *** ctswc_top.sv ***
// Function
// (R01) Sleep bit sleeps controller, clear resumes.
// (R02) Sleep bit separate from mode output bits.
// (R03) Remote wakeup restores control word to default.
// (R04) Clearing sleep bit performs local wakeup.
// (R05) Mode codes 0..3, reset normal.
// (R06) External type rejects mode setting.
// (R07) Sleep rejected unless communication started.
// (R08) Asleep: no traffic, transmissions held.
// (R09) Wakeup frame wakes, not stored nor acknowledged.
// (R10) Wakeup frame end returns to normal.
// (R11) Remote node retransmits unacknowledged wakeup frame.
// (R12) Remote raises wakeup level before wakeup frame.
// (R13) Queued transmissions resume exactly after wakeup.
// (R14) Remote wakeup visible in mode and event.
// (R15) Onewire wakeup mode only on onewire ports.
// (R16) Application times the wakeup level itself.
// (R17) Onewire fast mode disables waveshaping.
// (R18) Fast mode never combined with sleep.
// (R19) Type switch causes no bus disturbance.
// (R20) Host stops communication before type change.
// (R21) Sleep mode sleeps transceiver and controller.
// (R22) Normal after sleep wakes both locally.
// (R23) Low bits drive mode outputs, default set.
// (R24) Type codes 0..3, 4 disconnects.
// (R25) Bus receive synchronised before wake detection.
// (R26) Mode changes apply at frame boundary.
//
// Implementation choices: the register offsets and the APB interface to the registers.
module ctswc_top #(
	parameter int IDLE_CYCLES = ctswc_pkg::CTSWC_IDLE_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_can_rx,
	input wire logic i_frame_busy,
	output logic o_ctrl_sleep,
	output logic o_xcvr_sleep,
	output logic o_tx_hold,
	output logic o_rx_suppress,
	output logic o_wake_level,
	output logic o_waveshape_off,
	output logic o_disconnect,
	output logic [2:0] o_xcvr_type,
	output logic o_xcvr_mode_out_a,
	output logic o_xcvr_mode_out_b,
	output logic o_wake_event
);
	import ctswc_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic rx_sync, acc, wr, reject;
	logic next_pready, next_pslverr;
	logic [31:0] next_prdata;
	logic mode_out_a, mode_out_b, ctrl_sleep_bit;
	logic next_mode_out_a, next_mode_out_b, next_ctrl_sleep_bit;
	logic started, wake_flag, err_flag;
	logic next_started, next_wake_flag, next_err_flag;
	ctswc_mode_t mode, next_mode;
	ctswc_type_t xtype, eff_type, next_xtype, next_eff_type;
	ctswc_state_t state, next_state;
	logic [15:0] idle_cnt, next_idle_cnt;
	logic sleep_req, wake_done, next_wake_level, next_waveshape_off, next_wake_event;
	logic next_ctrl_sleep, next_xcvr_sleep, next_tx_hold, next_rx_suppress;

	// ****************************************************************
	// Bus receive synchroniser
	// ****************************************************************
	// The receive pin is brought into the clock domain before its level is used.
	ctswc_sync #(
		.RESET_VALUE(1'b1)
	) u_rx_sync (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_async(i_can_rx),
		.o_sync(rx_sync) // R25
	);

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// One wait state: the answer is prepared, then pready rises.
	assign acc = i_psel && i_penable && o_pready;
	assign wr = acc && i_pwrite;

	// Checks whether a write would be refused and prepares read data.
	always_comb begin
		next_pready = i_psel && i_penable && !o_pready;
		next_prdata = o_prdata;
		next_pslverr = o_pslverr;
		reject = 1'b0;
		case (i_paddr)
			CTSWC_OFS_EXT_OUT: begin
				reject = i_pwrite && (eff_type != CTSWC_TYPE_EXTERNAL);
			end
			CTSWC_OFS_MODE: begin
				if (i_pwrite) begin
					if (eff_type == CTSWC_TYPE_EXTERNAL) begin
						reject = 1'b1; // R06
					end else if (i_pwdata[1:0] == CTSWC_MODE_SLEEP && !started) begin
						reject = 1'b1; // R07
					end else if (i_pwdata[1] && eff_type != CTSWC_TYPE_ONEWIRE) begin
						reject = 1'b1; // R15
					end else if (i_pwdata[1:0] == CTSWC_MODE_ONEWIRE_FAST
						&& state != CTSWC_ST_NORMAL) begin
						reject = 1'b1; // R18
					end else if (i_pwdata[31:2] != 30'h0) begin
						reject = 1'b1;
					end
				end
			end
			CTSWC_OFS_TYPE: begin
				reject = i_pwrite && (started || i_pwdata > 32'h4); // R20
			end
			CTSWC_OFS_COMM, CTSWC_OFS_STATUS: begin
				reject = 1'b0;
			end
			default: begin
				reject = 1'b1;
			end
		endcase
		if (next_pready) begin
			next_pslverr = reject;
			next_prdata = 32'h0;
			if (!i_pwrite) begin
				case (i_paddr)
					CTSWC_OFS_EXT_OUT: begin
						next_prdata[CTSWC_EXT_A_BIT] = mode_out_a;
						next_prdata[CTSWC_EXT_B_BIT] = mode_out_b;
						next_prdata[CTSWC_EXT_SLEEP_BIT] = ctrl_sleep_bit;
					end
					CTSWC_OFS_MODE: begin
						next_prdata[1:0] = mode; // R14
					end
					CTSWC_OFS_TYPE: begin
						next_prdata[2:0] = xtype;
					end
					CTSWC_OFS_COMM: begin
						next_prdata[CTSWC_COMM_START_BIT] = started;
					end
					CTSWC_OFS_STATUS: begin
						next_prdata[CTSWC_ST_ASLEEP_BIT] = (state == CTSWC_ST_SLEEP);
						next_prdata[CTSWC_ST_WAKE_BIT] = wake_flag;
						next_prdata[CTSWC_ST_ERR_BIT] = err_flag;
						next_prdata[CTSWC_ST_BUSY_BIT] = i_frame_busy;
						next_prdata[CTSWC_ST_HOLD_BIT] = o_tx_hold;
						next_prdata[CTSWC_ST_WFRAME_BIT] = (state == CTSWC_ST_WAKE_FRAME);
					end
					default: begin
						next_prdata = 32'h0;
					end
				endcase
			end
		end else if (!i_psel) begin
			next_pslverr = 1'b0;
		end
	end

	// Registers the bus answer.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= next_pready;
			o_prdata <= next_prdata;
			o_pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Applies software writes; a finished remote wakeup overrides them.
	always_comb begin
		next_mode_out_a = mode_out_a;
		next_mode_out_b = mode_out_b;
		next_ctrl_sleep_bit = ctrl_sleep_bit;
		next_mode = mode;
		next_xtype = xtype;
		next_started = started;
		next_wake_flag = wake_flag;
		next_err_flag = err_flag;
		if (wr && !reject) begin
			case (i_paddr)
				CTSWC_OFS_EXT_OUT: begin
					next_mode_out_a = i_pwdata[CTSWC_EXT_A_BIT]; // R23
					next_mode_out_b = i_pwdata[CTSWC_EXT_B_BIT]; // R23
					next_ctrl_sleep_bit = i_pwdata[CTSWC_EXT_SLEEP_BIT]; // R02
				end
				CTSWC_OFS_MODE: begin
					next_mode = ctswc_mode_t'(i_pwdata[1:0]); // R05
				end
				CTSWC_OFS_TYPE: begin
					next_xtype = ctswc_type_t'(i_pwdata[2:0]); // R24
				end
				CTSWC_OFS_COMM: begin
					next_started = i_pwdata[CTSWC_COMM_START_BIT];
				end
				CTSWC_OFS_STATUS: begin
					if (i_pwdata[CTSWC_ST_WAKE_BIT]) begin
						next_wake_flag = 1'b0;
					end
					if (i_pwdata[CTSWC_ST_ERR_BIT]) begin
						next_err_flag = 1'b0;
					end
				end
				default: begin
					next_started = started;
				end
			endcase
		end
		if (wr && reject) begin
			next_err_flag = 1'b1; // R07
		end
		// A remote wakeup returns the control word and the mode to the communicating default.
		if (wake_done) begin
			next_mode_out_a = CTSWC_EXT_OUT_RESET[CTSWC_EXT_A_BIT]; // R03
			next_mode_out_b = CTSWC_EXT_OUT_RESET[CTSWC_EXT_B_BIT]; // R03
			next_ctrl_sleep_bit = CTSWC_EXT_OUT_RESET[CTSWC_EXT_SLEEP_BIT]; // R03
			next_mode = CTSWC_MODE_NORMAL; // R14
			next_wake_flag = 1'b1; // R14
		end
	end

	// Registers the configuration.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			mode_out_a <= CTSWC_EXT_OUT_RESET[CTSWC_EXT_A_BIT];
			mode_out_b <= CTSWC_EXT_OUT_RESET[CTSWC_EXT_B_BIT];
			ctrl_sleep_bit <= CTSWC_EXT_OUT_RESET[CTSWC_EXT_SLEEP_BIT];
			mode <= CTSWC_MODE_NORMAL;
			xtype <= ctswc_type_t'(CTSWC_TYPE_RESET);
			started <= 1'b0;
			wake_flag <= 1'b0;
			err_flag <= 1'b0;
		end else begin
			mode_out_a <= next_mode_out_a;
			mode_out_b <= next_mode_out_b;
			ctrl_sleep_bit <= next_ctrl_sleep_bit;
			mode <= next_mode;
			xtype <= next_xtype;
			started <= next_started;
			wake_flag <= next_wake_flag;
			err_flag <= next_err_flag;
		end
	end

	// ****************************************************************
	// Sleep and wakeup state machine
	// ****************************************************************
	// External transceivers sleep through the control bit, internal ones through the mode.
	assign sleep_req = (eff_type == CTSWC_TYPE_EXTERNAL) ? ctrl_sleep_bit
		: (mode == CTSWC_MODE_SLEEP);

	// Walks normal, sleep and the wakeup frame.
	always_comb begin
		next_state = state;
		next_idle_cnt = 16'h0;
		wake_done = 1'b0;
		next_eff_type = eff_type;
		case (state)
			CTSWC_ST_NORMAL: begin
				// Sleep and type changes wait until no frame is on the bus.
				if (!i_frame_busy) begin
					next_eff_type = xtype; // R19
					if (sleep_req && started) begin
						next_state = CTSWC_ST_SLEEP; // R26
					end
				end
			end
			CTSWC_ST_SLEEP: begin
				if (!sleep_req) begin
					next_state = CTSWC_ST_NORMAL; // R04
				end else if (!rx_sync) begin
					next_state = CTSWC_ST_WAKE_FRAME; // R09
				end
			end
			CTSWC_ST_WAKE_FRAME: begin
				if (!sleep_req) begin
					next_state = CTSWC_ST_NORMAL; // R22
				end else if (rx_sync) begin
					next_idle_cnt = idle_cnt + 16'h1;
					if (idle_cnt == 16'(IDLE_CYCLES - 1)) begin
						next_state = CTSWC_ST_NORMAL; // R10
						next_idle_cnt = 16'h0;
						wake_done = 1'b1;
					end
				end
			end
			default: begin
				next_state = CTSWC_ST_NORMAL;
			end
		endcase
	end

	// Registers the state machine.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state <= CTSWC_ST_NORMAL;
			idle_cnt <= 16'h0;
			eff_type <= ctswc_type_t'(CTSWC_TYPE_RESET);
		end else begin
			state <= next_state;
			idle_cnt <= next_idle_cnt;
			eff_type <= next_eff_type;
		end
	end

	// ****************************************************************
	// Transceiver and controller outputs
	// ****************************************************************
	// Derives the pin levels; speed and level modes change between frames only.
	always_comb begin
		next_ctrl_sleep = (state == CTSWC_ST_SLEEP); // R01
		next_xcvr_sleep = (state == CTSWC_ST_SLEEP) && (eff_type != CTSWC_TYPE_EXTERNAL); // R21
		next_tx_hold = (state != CTSWC_ST_NORMAL); // R08
		next_rx_suppress = (state != CTSWC_ST_NORMAL); // R09
		next_wake_level = o_wake_level;
		next_waveshape_off = o_waveshape_off;
		if (!i_frame_busy) begin
			next_wake_level = (state == CTSWC_ST_NORMAL) && (eff_type == CTSWC_TYPE_ONEWIRE)
				&& (mode == CTSWC_MODE_ONEWIRE_WAKE); // R15
			next_waveshape_off = (state == CTSWC_ST_NORMAL) && (eff_type == CTSWC_TYPE_ONEWIRE)
				&& (mode == CTSWC_MODE_ONEWIRE_FAST); // R17
		end
		next_wake_event = wake_done; // R14
	end

	// Registers every transceiver and controller output pin.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_ctrl_sleep <= 1'b0;
			o_xcvr_sleep <= 1'b0;
			o_tx_hold <= 1'b0;
			o_rx_suppress <= 1'b0;
			o_wake_level <= 1'b0;
			o_waveshape_off <= 1'b0;
			o_disconnect <= 1'b0;
			o_xcvr_type <= CTSWC_TYPE_RESET;
			o_xcvr_mode_out_a <= CTSWC_EXT_OUT_RESET[CTSWC_EXT_A_BIT];
			o_xcvr_mode_out_b <= CTSWC_EXT_OUT_RESET[CTSWC_EXT_B_BIT];
			o_wake_event <= 1'b0;
		end else begin
			o_ctrl_sleep <= next_ctrl_sleep;
			o_xcvr_sleep <= next_xcvr_sleep;
			o_tx_hold <= next_tx_hold; // R13
			o_rx_suppress <= next_rx_suppress;
			o_wake_level <= next_wake_level;
			o_waveshape_off <= next_waveshape_off;
			o_disconnect <= (eff_type == CTSWC_TYPE_DISCONNECT); // R24
			o_xcvr_type <= eff_type;
			o_xcvr_mode_out_a <= mode_out_a; // R23
			o_xcvr_mode_out_b <= mode_out_b; // R23
			o_wake_event <= next_wake_event;
		end
	end

endmodule : ctswc_top

// *** ctswc_pkg.sv ***
package ctswc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] CTSWC_OFS_EXT_OUT = 8'h00;
	localparam logic [7:0] CTSWC_OFS_MODE = 8'h04;
	localparam logic [7:0] CTSWC_OFS_TYPE = 8'h08;
	localparam logic [7:0] CTSWC_OFS_COMM = 8'h0c;
	localparam logic [7:0] CTSWC_OFS_STATUS = 8'h10;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTSWC_EXT_A_BIT = 0;
	localparam int CTSWC_EXT_B_BIT = 1;
	localparam int CTSWC_EXT_SLEEP_BIT = 8;
	localparam int CTSWC_COMM_START_BIT = 0;
	localparam int CTSWC_ST_ASLEEP_BIT = 0;
	localparam int CTSWC_ST_WAKE_BIT = 1;
	localparam int CTSWC_ST_ERR_BIT = 2;
	localparam int CTSWC_ST_BUSY_BIT = 3;
	localparam int CTSWC_ST_HOLD_BIT = 4;
	localparam int CTSWC_ST_WFRAME_BIT = 5;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [31:0] CTSWC_EXT_OUT_RESET = 32'h0000_0003;
	localparam logic [31:0] CTSWC_EXT_OUT_MASK = 32'h0000_0103;
	localparam logic [2:0] CTSWC_TYPE_RESET = 3'h0;
	localparam int CTSWC_IDLE_CYCLES = 16;

	// Transceiver mode setting.
	typedef enum logic [1:0] {
		CTSWC_MODE_NORMAL = 2'h0,
		CTSWC_MODE_SLEEP = 2'h1,
		CTSWC_MODE_ONEWIRE_WAKE = 2'h2,
		CTSWC_MODE_ONEWIRE_FAST = 2'h3
	} ctswc_mode_t;

	// Transceiver type setting.
	typedef enum logic [2:0] {
		CTSWC_TYPE_FAST_DIFF = 3'h0,
		CTSWC_TYPE_FAULT_TOLERANT = 3'h1,
		CTSWC_TYPE_ONEWIRE = 3'h2,
		CTSWC_TYPE_EXTERNAL = 3'h3,
		CTSWC_TYPE_DISCONNECT = 3'h4
	} ctswc_type_t;

	// Power state of the port.
	typedef enum logic [1:0] {
		CTSWC_ST_NORMAL,
		CTSWC_ST_SLEEP,
		CTSWC_ST_WAKE_FRAME
	} ctswc_state_t;

endpackage : ctswc_pkg

// *** ctswc_sync.sv ***
module ctswc_sync #(
	parameter logic RESET_VALUE = 1'b1
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_async,
	output logic o_sync
);

	logic stage_a;
	logic next_stage_a;
	logic next_sync;

	// Two flip-flops in series; only the second one is read outside.
	always_comb begin
		next_stage_a = i_async;
		next_sync = stage_a;
	end

	// Registers the synchroniser chain.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			stage_a <= RESET_VALUE;
			o_sync <= RESET_VALUE;
		end else begin
			stage_a <= next_stage_a;
			o_sync <= next_sync;
		end
	end

endmodule : ctswc_sync

// *** ctswc_top_assertions.sv ***
module ctswc_top_assertions (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_frame_busy,
	input wire logic o_pready,
	input wire logic o_ctrl_sleep,
	input wire logic o_xcvr_sleep,
	input wire logic o_tx_hold,
	input wire logic o_rx_suppress,
	input wire logic o_waveshape_off,
	input wire logic o_disconnect,
	input wire logic [2:0] o_xcvr_type,
	input wire logic o_xcvr_mode_out_a,
	input wire logic o_xcvr_mode_out_b,
	input wire logic o_wake_event
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************************************
	// Port checks
	// ****************************************************************
	// All checks use the system clock and rest while reset is low.
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);
	a_sleep_holds: assert property (o_ctrl_sleep |-> o_tx_hold && o_rx_suppress)
		else $error("sleep without hold");
	a_both_sleep: assert property (o_ctrl_sleep && o_xcvr_type != 3'h3 |-> o_xcvr_sleep)
		else $error("transceiver awake");
	a_wake_pulse: assert property (o_wake_event |=> !o_wake_event)
		else $error("long wake pulse");
	a_wake_restore: assert property ($rose(o_wake_event) |-> ##[0:2]
		(o_xcvr_mode_out_a && o_xcvr_mode_out_b && !o_tx_hold)) else $error("no restore");
	a_no_fast_sleep: assert property (o_xcvr_sleep |-> !o_waveshape_off)
		else $error("fast while asleep");
	a_disc_type: assert property (o_disconnect == (o_xcvr_type == 3'h4))
		else $error("disconnect wrong");
	a_ext_awake: assert property (o_xcvr_type == 3'h3 |-> !o_xcvr_sleep)
		else $error("external slept");
	a_type_frozen: assert property (i_frame_busy |-> ##2 $stable(o_xcvr_type))
		else $error("type moved in frame");
	a_ready_time: assert property (i_psel && $rose(i_penable) |=> o_pready)
		else $error("late ready");
	a_reset_outs: assert property ($rose(i_reset_n) |-> o_xcvr_mode_out_a && o_xcvr_mode_out_b)
		else $error("mode outs low");
	c_wake: cover property (o_wake_event);
	c_sleep: cover property ($rose(o_ctrl_sleep));
	c_disc: cover property (o_disconnect);
endmodule : ctswc_top_assertions

bind ctswc_top ctswc_top_assertions chk_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_frame_busy(i_frame_busy), .o_pready(o_pready),
	.o_ctrl_sleep(o_ctrl_sleep), .o_xcvr_sleep(o_xcvr_sleep), .o_tx_hold(o_tx_hold),
	.o_rx_suppress(o_rx_suppress), .o_waveshape_off(o_waveshape_off),
	.o_disconnect(o_disconnect), .o_xcvr_type(o_xcvr_type),
	.o_xcvr_mode_out_a(o_xcvr_mode_out_a), .o_xcvr_mode_out_b(o_xcvr_mode_out_b),
	.o_wake_event(o_wake_event));

// *** ctswc_remote_node.sv ***
module ctswc_remote_node #(
	parameter int FRAME_LEN = 20,
	parameter int GAP_LEN = 12
) (
	input wire logic i_mclk,
	input wire logic i_send,
	output logic o_rx,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// Sends one frame of toggling bits, then the bus returns to recessive.
	task automatic send_frame();
		for (int k = 0; k < FRAME_LEN; k++) begin
			o_rx <= k[0];
			o_busy <= 1'b1;
			@(posedge i_mclk);
		end
		o_rx <= 1'b1;
		o_busy <= 1'b0;
	endtask : send_frame
	// A wakeup frame is never acknowledged, so the node repeats it after a gap.
	initial begin
		o_rx = 1'b1;
		o_busy = 1'b0;
		forever begin
			@(posedge i_mclk);
			if (i_send === 1'b1) begin
				// The sender marks the bus busy for one clock before the first frame, with the line still recessive.
				o_busy <= 1'b1;
				@(posedge i_mclk);
				send_frame();
				repeat (GAP_LEN) @(posedge i_mclk);
				send_frame();
			end
		end
	end
endmodule : ctswc_remote_node

// *** ctswc_top_tb.sv ***
module ctswc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ctswc_pkg::*;
	// ****************************************************************
	// Design, partner and clock
	// ****************************************************************
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic send = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic [31:0] seed = 32'hbfd62922;
	logic [31:0] o_prdata, rd, d;
	logic [2:0] o_xcvr_type;
	logic i_can_rx, i_frame_busy, o_pready, o_pslverr, o_ctrl_sleep, o_xcvr_sleep, o_tx_hold;
	logic o_rx_suppress, o_wake_level, o_waveshape_off, o_disconnect, o_wake_event, er;
	logic o_xcvr_mode_out_a, o_xcvr_mode_out_b;
	int n_fail = 0;
	int tests_run = 0;
	int n_wake = 0;
	ctswc_top #(.IDLE_CYCLES(4)) dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_can_rx(i_can_rx),
		.i_frame_busy(i_frame_busy), .o_ctrl_sleep(o_ctrl_sleep), .o_xcvr_sleep(o_xcvr_sleep),
		.o_tx_hold(o_tx_hold), .o_rx_suppress(o_rx_suppress), .o_wake_level(o_wake_level),
		.o_waveshape_off(o_waveshape_off), .o_disconnect(o_disconnect),
		.o_xcvr_type(o_xcvr_type), .o_xcvr_mode_out_a(o_xcvr_mode_out_a),
		.o_xcvr_mode_out_b(o_xcvr_mode_out_b), .o_wake_event(o_wake_event));
	ctswc_remote_node node_u (.i_mclk(i_mclk), .i_send(send), .o_rx(i_can_rx),
		.o_busy(i_frame_busy));
	// Free-running 25 MHz clock.
	initial forever #20 i_mclk = ~i_mclk;
	// Counts wake pulses.
	always @(posedge i_mclk) begin
		if (o_wake_event === 1'b1) n_wake <= n_wake + 1;
	end
	// ****************************************************************
	// Expectations and bus tasks
	// ****************************************************************
	// Sleep outputs {controller, transceiver, hold, suppress}.
	function automatic logic [3:0] slp(input logic s, input logic ext);
		return {s, s & ~ext, s, s};
	endfunction : slp
	// Refusal of a mode write made from the normal state once started.
	function automatic logic mode_err(input logic [31:0] m, input int t);
		return (t == 3) || (m > 32'h3) || (m >= 32'h2 && t != 2);
	endfunction : mode_err
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; the request holds until ready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= v;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_mclk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic e);
		apb(1'b1, a, v);
		chk({31'h0, er}, {31'h0, e});
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task automatic outs(input logic [3:0] e);
		repeat (3) @(posedge i_mclk);
		chk({28'h0, o_ctrl_sleep, o_xcvr_sleep, o_tx_hold, o_rx_suppress}, {28'h0, e});
	endtask : outs
	task automatic pulse();
		send <= 1'b1;
		@(posedge i_mclk);
		send <= 1'b0;
	endtask : pulse
	// Waits a bounded time for the next wake pulse.
	task automatic wake();
		int n = 0;
		int w0 = n_wake;
		while (n_wake == w0 && n < 200) begin
			@(posedge i_mclk);
			n++;
		end
		chk(32'(n < 200), 32'h1);
	endtask : wake
	task automatic complete_run();
		$display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge i_mclk);
		n_fail++;
		complete_run();
	end
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (2) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rdc(8'h00, CTSWC_EXT_OUT_RESET);
		rdc(8'h04, 32'h0);
		rdc(8'h08, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, er}, 32'h1);
		wr(8'h04, 32'h1, 1'b1);
		wr(8'h0c, 32'h1, 1'b0);
		wr(8'h04, 32'h1, 1'b0);
		outs(slp(1'b1, 1'b0));
		wr(8'h04, 32'h0, 1'b0);
		outs(slp(1'b0, 1'b0));
		$display("Test local wakeup done");
		wr(8'h04, 32'h1, 1'b0);
		pulse();
		repeat (8) @(posedge i_mclk);
		chk({30'h0, o_tx_hold, o_rx_suppress}, 32'h3);
		wake();
		outs(slp(1'b0, 1'b0));
		rdc(8'h04, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rd[CTSWC_ST_WAKE_BIT]}, 32'h1);
		repeat (40) @(posedge i_mclk);
		$display("Test remote wakeup done");
		pulse();
		wr(8'h04, 32'h1, 1'b0);
		outs(slp(1'b0, 1'b0));
		wake();
		repeat (40) @(posedge i_mclk);
		$display("Test deferred sleep done");
		for (int t = 0; t < 5; t++) begin
			wr(8'h0c, 32'h0, 1'b0);
			wr(8'h08, 32'(t), 1'b0);
			wr(8'h0c, 32'h1, 1'b0);
			rdc(8'h08, 32'(t));
			chk({28'h0, o_disconnect, o_xcvr_type}, {28'h0, t == 4, 3'(t)});
			wr(8'h00, 32'h3, t != 3);
			for (int k = 0; k < 5; k++) begin
				d = {29'h0, 3'($random(seed))};
				if (d == 32'h1) d = 32'h80000002;
				wr(8'h04, d, mode_err(d, t));
				repeat (2) @(posedge i_mclk);
				if (t == 2 && d < 32'h4) chk({o_waveshape_off, o_wake_level}, {d == 3, d == 2});
			end
			if (t == 2) begin
				wr(8'h04, 32'h2, 1'b0);
				repeat (2) @(posedge i_mclk);
				chk({31'h0, o_wake_level}, 32'h1);
				wr(8'h04, 32'h0, 1'b0);
				repeat (2) @(posedge i_mclk);
				chk({31'h0, o_wake_level}, 32'h0);
			end
			wr(8'h04, 32'h0, t == 3);
			if (t == 3) begin
				for (int k = 0; k < 4; k++) begin
					d = {30'h0, 2'($random(seed))};
					wr(8'h00, d, 1'b0);
					repeat (2) @(posedge i_mclk);
					chk({o_xcvr_mode_out_b, o_xcvr_mode_out_a}, d);
				end
				wr(8'h00, 32'h100, 1'b0);
				outs(slp(1'b1, 1'b1));
				chk({o_xcvr_mode_out_b, o_xcvr_mode_out_a}, 32'h0);
				wr(8'h00, 32'h0, 1'b0);
				outs(slp(1'b0, 1'b0));
				wr(8'h00, 32'h100, 1'b0);
				pulse();
				wake();
				rdc(8'h00, CTSWC_EXT_OUT_RESET);
				repeat (40) @(posedge i_mclk);
			end
		end
		$display("Test type and mode codes done");
		wr(8'h08, 32'h1, 1'b1);
		wr(8'h0c, 32'h0, 1'b0);
		wr(8'h08, 32'h5, 1'b1);
		complete_run();
	end
endmodule : ctswc_top_tb
